/* mss_defs.vh */
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH
// Register byte offsets
`define MSS_REG_CTRL      4'h0
`define MSS_REG_SETUP     4'h4
`define MSS_REG_FAULT_IN  4'h8
`define MSS_REG_STATUS    4'hc
// Control fields
`define MSS_CTRL_START    0
`define MSS_CTRL_BOOST    1
`define MSS_CTRL_FULLSPD  2
`define MSS_CTRL_CFGWIRE  3
`define MSS_CTRL_CURVAR   4
`define MSS_CTRL_PTCVAR   5
`define MSS_CTRL_PTCOK    6
// Setup reset value: start level 40, ramp 0.25 s, stop 0.25 s
`define MSS_SETUP_RST     32'h0005_0528
// Timing
`define MSS_CLK_HZ        100000000
`define MSS_TICK_US       1000
`define MSS_TICK_CYC      ((`MSS_CLK_HZ / 1000000) * `MSS_TICK_US)
`define MSS_BOOST_MS      500
`define MSS_BOOST_PCT     8'h55
`define MSS_FULL_PCT      8'h64
`define MSS_CURTO_MS      20000
`define MSS_BLINK_MS      200
`define MSS_PAUSE_MS      1200
`define MSS_SLOW_MS       1000
`define MSS_FAST_MS       150
// Fault codes
`define MSS_F_CURTO       4'h3
`define MSS_F_TEMP        4'h2
`endif

/* mss_tick.v */
`timescale 1ns/1ns
module mss_tick #(
    parameter CYC = 100000
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Tick
    output reg         tick_q
);
    reg [31:0] cnt_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == CYC - 1) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end
endmodule // mss_tick

/* mss_blink.v */
`timescale 1ns/1ns
`include "mss_defs.vh"
module mss_blink (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Control
    input  wire        tick,
    input  wire [3:0]  code,
    input  wire        cfg_mode,
    input  wire        cfg_fast,
    // LED
    output reg         led_q
);
    // Blink count per code: 9 and 10 skip a count
    function [3:0] blinks;
        input [3:0] c;
        begin
            if (c == 4'h9)
                blinks = 4'ha;
            else if (c == 4'ha)
                blinks = 4'hb;
            else
                blinks = c;
        end
    endfunction
    reg [15:0] ms_q;
    reg [4:0]  n_q;
    localparam [15:0] FAST_MS = `MSS_FAST_MS;
    localparam [15:0] SLOW_MS = `MSS_SLOW_MS;
    wire [15:0] per = cfg_fast ? FAST_MS : SLOW_MS;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_q  <= 16'h0;
            n_q   <= 5'h0;
            led_q <= 1'b0;
        end else if (cfg_mode) begin
            if (tick) begin
                if (ms_q >= per - 16'h1) begin
                    ms_q  <= 16'h0;
                    led_q <= ~led_q;
                end else
                    ms_q <= ms_q + 16'h1;
            end
        end else if (code == 4'h0) begin
            ms_q  <= 16'h0;
            n_q   <= 5'h0;
            led_q <= 1'b0;
        end else if (tick) begin
            // Halves alternate on/off; extra halves form the pause
            if (ms_q >= `MSS_BLINK_MS - 1) begin
                ms_q <= 16'h0;
                if (n_q >= {blinks(code), 1'b0} + 5'h6) begin
                    n_q <= 5'h0;
                    led_q <= 1'b1;
                end else begin
                    n_q   <= n_q + 5'h1;
                    led_q <= (n_q + 5'h1 < {blinks(code), 1'b0}) &
                             ~n_q[0];
                end
            end else
                ms_q <= ms_q + 16'h1;
        end
    end
endmodule // mss_blink

/* mss_seq.v */
`timescale 1ns/1ns
`include "mss_defs.vh"
module mss_seq #(
    parameter TICK_CYC = `MSS_TICK_CYC,
    parameter CURTO_MS = `MSS_CURTO_MS
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Nonvolatile reset mode
    input  wire        nv_mode,
    output reg         nv_wr_q,
    output reg         nv_data_q,
    // Outputs to power stage and indicators
    output reg  [7:0]  drive_level_q,
    output reg         current_mode_q,
    output reg         fault_relay_q,
    output reg         bypass_status_relay_q,
    output reg         bypass_relay_q,
    output reg         led_yellow_q
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_BOOST = 3'h1;
    localparam ST_RAMP  = 3'h2;
    localparam ST_RUN   = 3'h3;
    localparam ST_STOP  = 3'h4;
    localparam ST_FAULT = 3'h5;
    localparam ST_CFG   = 3'h6;
    localparam [15:0] BOOST_MS = `MSS_BOOST_MS;
    localparam [15:0] CURTO_LIM = CURTO_MS;
    // Settle time before wiring and stored mode are sampled
    localparam [3:0]  WAKE_CYC = 4'h7;

    // Registers
    reg [6:0]  ctrl_q;
    reg [31:0] setup_q;
    reg [3:0]  fin_q;
    reg [2:0]  st_q;
    reg [3:0]  code_q;
    reg        mode_q;
    reg        start_q;
    reg        armed_q;
    reg [3:0]  wake_q;
    reg        cfg_done_q;
    reg [15:0] ms_q;
    reg [15:0] ramp_q;
    reg [7:0]  acc_q;
    // Address phase capture
    reg        dph_q;
    reg        dwr_q;
    reg [3:0]  dadr_q;

    wire       tick;
    wire       led_w;
    wire       start  = ctrl_q[`MSS_CTRL_START];
    wire       rise   = start & ~start_q;
    wire       fall   = ~start & start_q;
    // Setup fields: start level %, ramp/stop in 50 ms units, limit, grad
    wire [7:0] st_lvl = setup_q[7:0];
    wire [7:0] ramp_u = setup_q[15:8];
    wire [7:0] stop_u = setup_q[23:16];
    wire [3:0] lim    = setup_q[27:24];
    wire [3:0] grad   = setup_q[31:28];
    wire [15:0] ramp_ms = {8'h0, ramp_u} * 16'd50;
    wire [15:0] stop_ms = {8'h0, stop_u} * 16'd50;
    // Only the first sixteen bytes are mapped; mirrors would alias CTRL
    wire        in_map  = (haddr[31:4] == 28'h0);
    wire [15:0] ramp_add = (({8'h0, `MSS_FULL_PCT - st_lvl}) *
                           {8'h0, ms_q[7:0]}) /
                           (ramp_ms[15:8] + 16'h1) >> 8;
    wire [15:0] stop_sub = ({8'h0, ms_q[15:8]} * 16'h64) /
                           ({8'h0, stop_ms[15:8]} + 16'h1);
    wire boost_ok = ctrl_q[`MSS_CTRL_BOOST] & ~ctrl_q[`MSS_CTRL_PTCVAR];
    wire hot = ctrl_q[`MSS_CTRL_PTCVAR] & ~ctrl_q[`MSS_CTRL_PTCOK];
    wire [3:0] fault_w = hot ? `MSS_F_TEMP : fin_q;

    mss_tick #(
        .CYC (TICK_CYC)
    ) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick_q  (tick)
    );

    mss_blink u_blink (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .tick     (tick),
        .code     (code_q),
        .cfg_mode (st_q == ST_CFG),
        .cfg_fast (mode_q),
        .led_q    (led_w)
    );

    // Bus slave: zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q     <= 1'b0;
            dwr_q     <= 1'b0;
            dadr_q    <= 4'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                dph_q  <= hsel & htrans[1] & in_map;
                dwr_q  <= hwrite;
                dadr_q <= haddr[3:0];
                if (hsel & htrans[1] & ~hwrite) begin
                    case ({in_map, haddr[3:0]})
                    {1'b1, `MSS_REG_CTRL}:     hrdata <= {25'h0, ctrl_q};
                    {1'b1, `MSS_REG_SETUP}:    hrdata <= setup_q;
                    {1'b1, `MSS_REG_FAULT_IN}: hrdata <= {28'h0, fin_q};
                    {1'b1, `MSS_REG_STATUS}:   hrdata <= {16'h0, mode_q,
                                                code_q, st_q, acc_q};
                    default:           hrdata <= 32'h0;
                    endcase
                end
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= 7'h0;
            setup_q <= `MSS_SETUP_RST;
            fin_q   <= 4'h0;
        end else if (dph_q & dwr_q) begin
            case (dadr_q)
            `MSS_REG_CTRL:     ctrl_q  <= hwdata[6:0];
            `MSS_REG_SETUP:    setup_q <= hwdata;
            `MSS_REG_FAULT_IN: fin_q   <= hwdata[3:0];
            default:           ctrl_q  <= ctrl_q;
            endcase
        end
    end

    // Sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q       <= ST_IDLE;
            code_q     <= 4'h0;
            mode_q     <= 1'b0;
            start_q    <= 1'b0;
            armed_q    <= 1'b0;
            wake_q     <= 4'h0;
            cfg_done_q <= 1'b0;
            ms_q       <= 16'h0;
            ramp_q     <= 16'h0;
            acc_q      <= 8'h0;
            nv_wr_q    <= 1'b0;
            nv_data_q  <= 1'b0;
            drive_level_q         <= 8'h0;
            current_mode_q        <= 1'b0;
            fault_relay_q         <= 1'b0;
            bypass_status_relay_q <= 1'b0;
            bypass_relay_q        <= 1'b0;
            led_yellow_q          <= 1'b0;
        end else begin
            start_q      <= start;
            nv_wr_q      <= 1'b0;
            led_yellow_q <= led_w;
            if (!armed_q) begin
                // Wait so that wiring written right after release is seen
                wake_q <= wake_q + 4'h1;
                if (wake_q == WAKE_CYC) begin
                    armed_q <= 1'b1;
                    mode_q  <= nv_mode;
                    if (ctrl_q[`MSS_CTRL_CFGWIRE])
                        st_q <= ST_CFG;
                end
            end
            if (tick && st_q != ST_IDLE && st_q != ST_FAULT)
                ms_q <= ms_q + 16'h1;
            fault_relay_q <= (st_q != ST_FAULT) && (fault_w == 4'h0);
            case (st_q)
            ST_IDLE: begin
                drive_level_q <= 8'h0;
                bypass_relay_q <= 1'b0;
                bypass_status_relay_q <= 1'b0;
                ms_q <= 16'h0;
                if (fault_w != 4'h0) begin
                    code_q <= fault_w;
                    st_q   <= ST_FAULT;
                end else if (rise && armed_q) begin
                    current_mode_q <= ctrl_q[`MSS_CTRL_CURVAR];
                    acc_q <= 8'h0;
                    if (boost_ok) begin
                        st_q <= ST_BOOST;
                        drive_level_q <= `MSS_BOOST_PCT;
                    end else begin
                        st_q <= ST_RAMP;
                        drive_level_q <= st_lvl;
                    end
                end
            end
            ST_BOOST: begin
                drive_level_q <= `MSS_BOOST_PCT;
                if (fault_w != 4'h0) begin
                    code_q <= fault_w;
                    st_q   <= ST_FAULT;
                end else if (ms_q >= BOOST_MS) begin
                    ms_q <= 16'h0;
                    st_q <= ST_RAMP;
                end else if (fall)
                    st_q <= ST_STOP;
            end
            ST_RAMP: begin
                if (ctrl_q[`MSS_CTRL_CURVAR]) begin
                    // Level is current limit target in 0.5 xIN steps
                    if (tick && acc_q < {lim, 4'h0})
                        acc_q <= acc_q + {4'h0, grad} + 8'h1;
                    drive_level_q <= acc_q;
                end else if (ms_q < ramp_ms)
                    drive_level_q <= st_lvl + ramp_add[7:0];
                if (fault_w != 4'h0) begin
                    code_q <= fault_w;
                    st_q   <= ST_FAULT;
                end else if (fall) begin
                    ms_q <= 16'h0;
                    st_q <= ST_STOP;
                end else if (ctrl_q[`MSS_CTRL_CURVAR] &&
                             ms_q >= CURTO_LIM) begin
                    code_q <= `MSS_F_CURTO;
                    st_q   <= ST_FAULT;
                end else if (ctrl_q[`MSS_CTRL_CURVAR] ?
                             ctrl_q[`MSS_CTRL_FULLSPD] : ms_q >= ramp_ms) begin
                    drive_level_q <= `MSS_FULL_PCT;
                    bypass_relay_q <= 1'b1;
                    bypass_status_relay_q <= 1'b1;
                    st_q <= ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault_w != 4'h0) begin
                    code_q <= fault_w;
                    st_q   <= ST_FAULT;
                end else if (fall) begin
                    ms_q <= 16'h0;
                    bypass_relay_q <= 1'b0;
                    bypass_status_relay_q <= 1'b0;
                    st_q <= ST_STOP;
                end
            end
            ST_STOP: begin
                bypass_relay_q <= 1'b0;
                bypass_status_relay_q <= 1'b0;
                drive_level_q <= (ms_q >= stop_ms) ? 8'h0 :
                    `MSS_FULL_PCT - stop_sub[7:0];
                if (fault_w != 4'h0) begin
                    code_q <= fault_w;
                    st_q   <= ST_FAULT;
                end else if (ms_q >= stop_ms)
                    st_q <= ST_IDLE;
            end
            ST_FAULT: begin
                drive_level_q <= 8'h0;
                bypass_relay_q <= 1'b0;
                bypass_status_relay_q <= 1'b0;
                // Power cycle (hresetn) always clears; restart only in mode 1
                if (mode_q && rise && fault_w == 4'h0) begin
                    code_q <= 4'h0;
                    st_q   <= ST_IDLE;
                end
            end
            ST_CFG: begin
                drive_level_q <= 8'h0;
                if (fall)
                    cfg_done_q <= 1'b1;
                if (rise && cfg_done_q) begin
                    cfg_done_q <= 1'b0;
                    mode_q    <= ~mode_q;
                    nv_wr_q   <= 1'b1;
                    nv_data_q <= ~mode_q;
                end
            end
            default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // mss_seq

/* mss_seq_assertions.sv */
`timescale 1ns/1ns
module mss_seq_assertions #(
    parameter TICK_CYC = 10
) (
    // Clock and reset
    input wire       hclk,
    input wire       hresetn,
    // Stored mode
    input wire       nv_mode,
    input wire       nv_wr_q,
    input wire       nv_data_q,
    // Power stage and relays
    input wire [7:0] drive_level_q,
    input wire       fault_relay_q,
    input wire       bypass_status_relay_q,
    input wire       bypass_relay_q
);
    localparam int BOOST_MAX = 500 * TICK_CYC + 4;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles spent at the boost level
    reg [15:0] boost_cnt_q;
    always @(posedge hclk or negedge hresetn)
        if (!hresetn) boost_cnt_q <= 16'h0;
        else if (drive_level_q == 8'h55) boost_cnt_q <= boost_cnt_q + 16'h1;
        else boost_cnt_q <= 16'h0;
    property p_relay_pair;
        bypass_relay_q == bypass_status_relay_q;
    endproperty
    a_relay_pair: assert property (p_relay_pair)
        else $error("bypass relays disagree");
    property p_full_on_bypass;
        $rose(bypass_relay_q) |-> drive_level_q == 8'h64;
    endproperty
    a_full_on_bypass: assert property (p_full_on_bypass)
        else $error("bypass closed before full level");
    property p_level_range;
        drive_level_q <= 8'h64;
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("drive level above full");
    property p_boost_len;
        boost_cnt_q <= BOOST_MAX;
    endproperty
    a_boost_len: assert property (p_boost_len)
        else $error("boost level held too long");
    property p_no_start_in_fault;
        !fault_relay_q && $past(!fault_relay_q) |-> !$rose(bypass_relay_q);
    endproperty
    a_no_start_in_fault: assert property (p_no_start_in_fault)
        else $error("start completed while fault latched");
    property p_soft_stop;
        $fell(bypass_relay_q) && fault_relay_q |=> drive_level_q != 8'h00;
    endproperty
    a_soft_stop: assert property (p_soft_stop)
        else $error("stop cut drive at once");
    property p_nv_pulse;
        nv_wr_q |=> !nv_wr_q;
    endproperty
    a_nv_pulse: assert property (p_nv_pulse)
        else $error("store strobe longer than one cycle");
    property p_nv_flip;
        nv_wr_q |-> nv_data_q == !nv_mode;
    endproperty
    a_nv_flip: assert property (p_nv_flip)
        else $error("stored mode not the other one");
endmodule // mss_seq_assertions

/* mss_nv_model.sv */
`timescale 1ns/1ns
module mss_nv_model (
    // Clock
    input wire hclk,
    // Bench preload
    input wire preset_en,
    input wire preset_val,
    // Store port
    input wire nv_wr_q,
    input wire nv_data_q,
    output reg nv_mode
);
    initial nv_mode = 1'b0;
    // No reset: the choice must outlive a power cycle
    always @(posedge hclk)
        if (preset_en) nv_mode <= preset_val;
        else if (nv_wr_q) nv_mode <= nv_data_q;
endmodule // mss_nv_model

/* tb_mss_seq.sv */
`timescale 1ns/1ns
`include "mss_defs.vh"
`define MSS_CHK(a, b) begin \
    n_checks++; \
    if ((a) !== (b)) begin \
        miscompares++; \
        $display("Error at %0t: got %h, expected %h", $time, a, b); \
    end \
end
module tb_mss_seq;
    localparam TK = 2;
    localparam GAP = 800 * TK;
    localparam [31:0] A_CT = {28'h0, `MSS_REG_CTRL};
    localparam [31:0] A_SU = {28'h0, `MSS_REG_SETUP};
    localparam [31:0] A_FI = {28'h0, `MSS_REG_FAULT_IN};
    reg        hclk = 1'b0;
    reg        hresetn = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0]  htrans = 2'h0;
    reg        hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg        rd_ph = 1'b0;
    reg        preset_en = 1'b0;
    reg        preset_val = 1'b0;
    reg [31:0] r, e, exp_q[$];
    reg [7:0]  lvl;
    wire [31:0] hrdata;
    wire [7:0]  drive_level_q;
    wire hreadyout, hresp, nv_mode, nv_wr_q, nv_data_q, current_mode_q;
    wire fault_relay_q, bypass_status_relay_q, bypass_relay_q, led_yellow_q;
    int miscompares = 0, n_checks = 0, cyc = 0, last = 0, lg = 0, cnt = 0;
    int nr = 0, i, eb, seed = 65376, blk_q[$];
    bit in_grp = 0;
    mss_seq #(.TICK_CYC(TK), .CURTO_MS(20)) mss_seq_inst (.hclk, .hresetn,
        .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .nv_mode,
        .nv_wr_q, .nv_data_q, .drive_level_q, .current_mode_q,
        .fault_relay_q, .bypass_status_relay_q, .bypass_relay_q,
        .led_yellow_q);
    mss_nv_model mss_nv_model_inst (.hclk, .preset_en, .preset_val,
        .nv_wr_q, .nv_data_q, .nv_mode);
    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;
    task tk(input int n); repeat (n) @(posedge hclk); endtask
    task pwr;
        hresetn <= 1'b0;
        tk(5);
        hresetn <= 1'b1;
    endtask
    task ahb(input [31:0] a, input w, input [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        tk(1);
        while (!hreadyout) tk(1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        tk(1);
        while (!hreadyout) tk(1);
        rd_ph <= 1'b0;
    endtask
    task rd(input [31:0] a, input [31:0] x);
        exp_q.push_back(x);
        ahb(a, 1'b0, 32'h0);
    endtask
    task grp(input int n);
        blk_q.push_back(n);
        for (i = 0; i < 30000 && blk_q.size() > 0; i++) tk(1);
    endtask
    task rises(input int n);
        int n0;
        n0 = nr;
        for (i = 0; i < 20000 && nr < n0 + n; i++) tk(1);
    endtask
    task fault_wait;
        for (i = 0; i < 4000 && fault_relay_q !== 1'b0; i++) tk(1);
    endtask
    task preset(input v);
        preset_en <= 1'b1;
        preset_val <= v;
        tk(1);
        preset_en <= 1'b0;
    endtask
    task wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge hclk) if (rd_ph && hreadyout) begin
        e = exp_q.pop_front();
        `MSS_CHK(hrdata, e)
        `MSS_CHK(hresp, 1'b0)
    end
    // Long gap marks a group boundary; only whole groups are judged
    always @(posedge led_yellow_q) begin
        lg = cyc - last;
        last = cyc;
        nr++;
        if (lg > GAP) begin
            if (in_grp) begin
                eb = blk_q.pop_front();
                `MSS_CHK(cnt, eb)
            end
            in_grp = blk_q.size() > 0;
            cnt = 1;
        end else cnt++;
    end
    initial begin
        #990000;
        miscompares++;
        wrap_up();
    end
    initial begin
        pwr();
        rd(A_SU, `MSS_SETUP_RST);
        ahb(32'h10, 1'b1, $random(seed));
        rd(32'h10, 32'h0);
        r = $random(seed);
        lvl = 8'd40 + {3'h0, r[12:8]};
        ahb(A_SU, 1'b1, {r[3:0], 4'h2 + {2'h0, r[5:4]}, 16'h0101, lvl});
        ahb(A_CT, 1'b1, 32'h3);
        tk(20);
        `MSS_CHK(drive_level_q, `MSS_BOOST_PCT)
        for (i = 0; i < 5000 && bypass_relay_q !== 1'b1; i++) tk(1);
        `MSS_CHK(i >= 500 * TK, 1'b1)
        `MSS_CHK(bypass_status_relay_q, 1'b1)
        ahb(A_CT, 1'b1, 32'h0);
        for (i = 0; i < 5000 && drive_level_q !== 8'h0; i++) tk(1);
        `MSS_CHK(i >= 40 * TK, 1'b1)
        `MSS_CHK(bypass_relay_q, 1'b0)
        ahb(A_CT, 1'b1, 32'h11);
        tk(4);
        `MSS_CHK(current_mode_q, 1'b1)
        fault_wait();
        `MSS_CHK(fault_relay_q, 1'b0)
        grp(3);
        ahb(A_CT, 1'b1, 32'h0);
        ahb(A_CT, 1'b1, 32'h1);
        tk(300);
        `MSS_CHK({fault_relay_q, bypass_relay_q}, 2'h0)
        pwr();
        tk(20);
        `MSS_CHK(fault_relay_q, 1'b1)
        ahb(A_CT, 1'b1, 32'h63);
        tk(20);
        `MSS_CHK(drive_level_q !== `MSS_BOOST_PCT, 1'b1)
        ahb(A_CT, 1'b1, 32'h21);
        fault_wait();
        grp(2);
        for (eb = 9; eb < 11; eb++) begin
            pwr();
            ahb(A_FI, 1'b1, eb);
            grp(eb + 1);
        end
        preset(1'b1);
        pwr();
        ahb(A_FI, 1'b1, 32'h4);
        fault_wait();
        ahb(A_FI, 1'b1, 32'h0);
        ahb(A_CT, 1'b1, 32'h1);
        ahb(A_CT, 1'b1, 32'h0);
        ahb(A_CT, 1'b1, 32'h1);
        tk(200);
        `MSS_CHK(fault_relay_q, 1'b1)
        preset(1'b0);
        pwr();
        ahb(A_CT, 1'b1, 32'h8);
        rises(3);
        `MSS_CHK(lg > 1900 * TK && lg < 2100 * TK, 1'b1)
        ahb(A_CT, 1'b1, 32'h9);
        ahb(A_CT, 1'b1, 32'h8);
        ahb(A_CT, 1'b1, 32'h9);
        for (i = 0; i < 200 && nv_wr_q !== 1'b1; i++) tk(1);
        `MSS_CHK(nv_data_q, 1'b1)
        rises(3);
        `MSS_CHK(lg > 250 * TK && lg < 350 * TK, 1'b1)
        pwr();
        tk(2);
        `MSS_CHK(nv_mode, 1'b1)
        wrap_up();
    end
endmodule // tb_mss_seq
bind mss_seq mss_seq_assertions #(.TICK_CYC(TICK_CYC)) mss_chk_inst (
    .hclk, .hresetn, .nv_mode, .nv_wr_q, .nv_data_q, .drive_level_q,
    .fault_relay_q, .bypass_status_relay_q, .bypass_relay_q);
